// ### hdl/debug_cfg_defs.vh
`ifndef DEBUG_CFG_DEFS_VH
`define DEBUG_CFG_DEFS_VH
// Register indices on the debug register select field.
`define REG_CONFIG_STATUS  5'h00
`define REG_MEM_ATTR       5'h05
`define REG_ATTR_MATCH_0   5'h06
`define REG_TRIG_DEF       5'h07
`define REG_ATTR_MATCH_1   5'h16
`define REG_EXT_TRIG_DEF   5'h17
// Reset values.
`define MEM_ATTR_RESET     8'h05
`define ATTR_MATCH_RESET   32'h0000_0005
// Trigger state field encodings.
`define TSTATE_NONE        4'h0
`define TSTATE_WAIT_L1     4'h1
`define TSTATE_HIT_L1      4'h2
`define TSTATE_WAIT_L2     4'h5
`define TSTATE_HIT_L2      4'h6
// Configuration/status field positions.
`define CS_DOUBLE_FAULT    27
`define CS_HW_TRIG         26
`define CS_HALT_INSTR      25
`define CS_EXT_BREAK       24
`define CS_BREAK_IRQ       18
`define CS_TRACE_DIS       17
`define CS_BLOCK_CPU       16
`define CS_MAP             15
`define CS_TRACE_MON       14
`define CS_FORCE_MON       13
`define CS_USER_HALT       10
`define CS_SERIAL_EXEC     6
`define CS_IGNORE_IRQ      5
`define CS_SINGLE_STEP     4
`define CS_OWN_TRACE       3
`define CS_FORCE_DBG       1
`define CS_SUPPRESS_DBG    0
// Mask of configuration bits software may write.
`define CS_WRITE_MASK      32'h0007_FF7B
// Trigger definition level enables.
`define TD_L2_ENABLE       29
`define TD_L1_ENABLE       13
// Transfer type codes.
`define TT_NORMAL          2'h0
`define TT_EXTERNAL        2'h1
`define TT_EMULATOR        2'h2
`define TM_EMU_DATA        3'h5
`define TM_EMU_CODE        3'h6
// Extra cycles added per instruction in serial mode.
`define SERIAL_EXTRA_CYC   3'h5
`endif

// ### hdl/debug_config_attr_match.v
`include "debug_cfg_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module debug_config_attr_match #(
    parameter [3:0] REVISION = 4'h3 // Arbitrary revision value.
) (
    input  wire        clk,
    input  wire        rst_b,
    input  wire        portWrite,
    input  wire        portRead,
    input  wire        cpuWrite,
    input  wire [4:0]  regSel,
    input  wire [31:0] writeData,
    input  wire        memCmd,
    input  wire        memCmdRead,
    input  wire [1:0]  memCmdSize,
    input  wire        enterDebugTrigger,
    input  wire        enterDebugHalt,
    input  wire        enterDebugBreak,
    input  wire        catastrophicHalt,
    input  wire        resumeCmd,
    input  wire        coreHalted,
    input  wire        level1Hit,
    input  wire        level2Hit,
    input  wire        instrSample,
    input  wire        traceException,
    input  wire        irqRequest,
    input  wire        userEntry,
    input  wire        spaceIdLoad,
    input  wire        syncPcCmd,
    input  wire [7:0]  currentSpaceId,
    input  wire        traceIdle,
    input  wire [7:0]  traceNibbleIn,
    input  wire        externalBreakIn,
    input  wire        traceClockIn,
    input  wire        busValid,
    input  wire        busRead,
    input  wire [1:0]  busSize,
    input  wire [1:0]  busType,
    input  wire [2:0]  busModifier,
    input  wire [7:0]  busSpaceId,
    output reg  [31:0] readData,
    output reg         readValid,
    output reg         debugModeOut,
    output reg         debugIrq,
    output reg         traceClockOut,
    output reg  [7:0]  traceNibbleBus,
    output reg         attrMatch0,
    output reg         attrMatch1,
    output reg         monitorMode,
    output reg         emuSpecialSpace,
    output reg  [1:0]  emuTypeOut,
    output reg         sramCacheDisable,
    output reg         serialExecution,
    output reg  [2:0]  serialExtraCycles,
    output reg         singleStepHalt,
    output reg         irqAccept,
    output reg         ownershipEmit,
    output reg  [1:0]  operandCaptureSel,
    output reg  [1:0]  branchTargetCount,
    output reg  [7:0]  memAttr
);

    // Configuration and status storage.
    reg  [3:0]  trigState;
    reg         doubleFault;
    reg         hwTrigFlag;
    reg         haltFlag;
    reg         breakFlag;
    reg  [31:0] cfgBits;
    reg  [31:0] attrMatch0Reg;
    reg  [31:0] attrMatch1Reg;
    reg  [31:0] trigDef;
    reg  [31:0] extTrigDef;
    reg  [1:0]  breakSync;
    reg         breakPrev;
    reg         irqPending;
    reg  [1:0]  traceClkSync;
    reg         stepArmed;

    // Write gating. The debug port may always write; the processor is held off
    // by the block bit. A trigger definition write from either side restarts the
    // trigger state, so software must program triggers before enabling them.
    wire portCfgWrite = portWrite && regSel == `REG_CONFIG_STATUS;
    wire cpuAllowed   = cpuWrite && !cfgBits[`CS_BLOCK_CPU];
    wire anyWrite     = portWrite || cpuAllowed;
    wire trigDefWrite = anyWrite && (regSel == `REG_TRIG_DEF || regSel == `REG_EXT_TRIG_DEF);
    wire readClears   = portRead && regSel == `REG_CONFIG_STATUS &&
                        (trigState == `TSTATE_HIT_L2 ||
                        (trigState == `TSTATE_HIT_L1 && !trigDef[`TD_L2_ENABLE]));
    wire breakFall    = breakPrev && !breakSync[1];

    wire [31:0] statusView = (cfgBits & `CS_WRITE_MASK) |
                             {trigState, doubleFault, hwTrigFlag, haltFlag, breakFlag,
                              REVISION, 20'h00000};

    // Next trigger state; hits advance, writes and qualifying reads clear.
    reg [3:0] next_trigState;
    always @* begin
        next_trigState = trigState;
        if (trigState == `TSTATE_NONE && trigDef[`TD_L1_ENABLE])
            next_trigState = `TSTATE_WAIT_L1;
        else if (trigState == `TSTATE_WAIT_L1 && level1Hit)
            next_trigState = trigDef[`TD_L2_ENABLE] ? `TSTATE_WAIT_L2 : `TSTATE_HIT_L1;
        else if (trigState == `TSTATE_WAIT_L2 && level2Hit)
            next_trigState = `TSTATE_HIT_L2;
        if (trigDefWrite || readClears)
            next_trigState = `TSTATE_NONE;
    end

    // Attribute comparison against a match register; masked bits compare equal.
    // The low byte holds direction, size, type and modifier, the next byte the
    // mask for each of them. The space id only counts when its qualify bit is set,
    // so a cleared qualify bit leaves the comparison as it was without ids.
    function matchAttr;
        input [31:0] ar;
        input        rd;
        input [1:0]  sz;
        input [1:0]  tt;
        input [2:0]  tm;
        input [7:0]  sid;
        reg   [7:0]  diff;
        begin
            diff = {rd, sz, tt, tm} ^ ar[7:0];
            matchAttr = ((diff & ~ar[15:8]) == 8'h00) &&
                        (!ar[24] || sid == ar[23:16]);
        end
    endfunction

    // Trigger state and the break pin synchroniser.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            trigState <= `TSTATE_NONE;
            breakSync <= 2'h3;
            breakPrev <= 1'b1;
        end else begin
            trigState <= next_trigState;
            // The pin idles high, so the chain resets high to avoid a false edge.
            breakSync <= {breakSync[0], externalBreakIn};
            breakPrev <= breakSync[1];
        end
    end

    // Halt-cause flags; a new cause in the resume cycle wins over the clear.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            doubleFault <= 1'b0;
            hwTrigFlag  <= 1'b0;
            haltFlag    <= 1'b0;
            breakFlag   <= 1'b0;
        end else begin
            if (catastrophicHalt)
                doubleFault <= 1'b1;
            else if (resumeCmd)
                doubleFault <= 1'b0;
            if (enterDebugTrigger)
                hwTrigFlag <= 1'b1;
            else if (resumeCmd)
                hwTrigFlag <= 1'b0;
            if (enterDebugHalt)
                haltFlag <= 1'b1;
            else if (resumeCmd)
                haltFlag <= 1'b0;
            if (enterDebugBreak)
                breakFlag <= 1'b1;
            else if (resumeCmd)
                breakFlag <= 1'b0;
        end
    end

    // Configuration word and trigger definition registers.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfgBits       <= 32'h00000000;
            trigDef       <= 32'h00000000;
            extTrigDef    <= 32'h00000000;
            attrMatch0Reg <= `ATTR_MATCH_RESET;
            attrMatch1Reg <= `ATTR_MATCH_RESET;
        end else begin
            // Config writes
            // A port write wins over a processor write in the same cycle.
            if (portCfgWrite)
                cfgBits <= writeData & `CS_WRITE_MASK;
            else if (cpuAllowed && regSel == `REG_CONFIG_STATUS)
                cfgBits <= (writeData & `CS_WRITE_MASK & ~(32'h1 << `CS_BLOCK_CPU)) |
                           (cfgBits & (32'h1 << `CS_BLOCK_CPU));
            if (anyWrite && regSel == `REG_TRIG_DEF)
                trigDef <= writeData;
            if (anyWrite && regSel == `REG_EXT_TRIG_DEF)
                extTrigDef <= writeData;
            if (anyWrite && regSel == `REG_ATTR_MATCH_0)
                attrMatch0Reg <= writeData;
            if (anyWrite && regSel == `REG_ATTR_MATCH_1)
                attrMatch1Reg <= writeData;
        end
    end

    // Memory attribute register for debug-port memory commands.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            memAttr <= `MEM_ATTR_RESET;
        end else begin
            if (anyWrite && (regSel == `REG_MEM_ATTR || regSel == `REG_ATTR_MATCH_0))
                memAttr[4:0] <= writeData[4:0];
            if (memCmd)
                memAttr[7:5] <= {memCmdRead, memCmdSize};
        end
    end

    // Pending debug interrupt and single-step arming.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irqPending <= 1'b0;
            stepArmed  <= 1'b0;
        end else begin
            // Pending debug interrupt
            // A new edge in a sample cycle stays pending for the next sample.
            if (cfgBits[`CS_BREAK_IRQ] && breakFall)
                irqPending <= 1'b1;
            else if (instrSample)
                irqPending <= 1'b0;
            if (resumeCmd)
                stepArmed <= 1'b1;
            else if (instrSample)
                stepArmed <= 1'b0;
        end
    end

    // Status readback towards the debug port; the processor has no read path.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            readData  <= 32'h00000000;
            readValid <= 1'b0;
        end else begin
            readValid <= portRead;
            readData  <= (portRead && regSel == `REG_CONFIG_STATUS) ? statusView : 32'h0;
        end
    end

    // Trace clock sampled by the core clock.
    // The link clock is foreign to the core clock, so it passes two flip-flops
    // first; the output copy therefore lags the input by two to three cycles.
    // Space id emission takes priority over idle status and core trace data.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            traceClkSync  <= 2'h0;
            traceClockOut <= 1'b0;
            traceNibbleBus <= 8'h00;
        end else begin
            traceClkSync <= {traceClkSync[0], traceClockIn};
            if (cfgBits[`CS_TRACE_DIS]) begin
                traceClockOut  <= 1'b0;
                traceNibbleBus <= 8'h00;
            end else begin
                traceClockOut <= traceClkSync[1];
                if (cfgBits[`CS_OWN_TRACE] && (userEntry || spaceIdLoad || syncPcCmd))
                    traceNibbleBus <= currentSpaceId;
                else if (traceIdle)
                    traceNibbleBus <= {4'h0, trigState};
                else
                    traceNibbleBus <= traceNibbleIn;
            end
        end
    end

    // Control outputs registered from configuration and core state.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            debugModeOut      <= 1'b0;
            debugIrq          <= 1'b0;
            attrMatch0        <= 1'b0;
            attrMatch1        <= 1'b0;
            monitorMode       <= 1'b0;
            emuSpecialSpace   <= 1'b0;
            emuTypeOut        <= `TT_NORMAL;
            sramCacheDisable  <= 1'b0;
            serialExecution   <= 1'b0;
            serialExtraCycles <= 3'h0;
            singleStepHalt    <= 1'b0;
            irqAccept         <= 1'b0;
            ownershipEmit     <= 1'b0;
            operandCaptureSel <= 2'h0;
            branchTargetCount <= 2'h0;
        end else begin
            debugModeOut <= cfgBits[`CS_FORCE_DBG] ||
                            (coreHalted && !cfgBits[`CS_SUPPRESS_DBG]);

            // The interrupt is raised only at an instruction sample point.
            debugIrq <= irqPending && instrSample;

            // Gated attribute match
            // Either level enable of the owning definition arms the comparison.
            attrMatch0 <= busValid && trigDef[`TD_L1_ENABLE] |
                          trigDef[`TD_L2_ENABLE] &&
                          matchAttr(attrMatch0Reg, busRead, busSize, busType,
                                    busModifier, busSpaceId);
            attrMatch1 <= busValid && extTrigDef[`TD_L1_ENABLE] |
                          extTrigDef[`TD_L2_ENABLE] &&
                          matchAttr(attrMatch1Reg, busRead, busSize, busType,
                                    busModifier, busSpaceId);

            // Monitor mode entry
            // Monitor mode is left only by a resume command.
            if (cfgBits[`CS_FORCE_MON] || (traceException && cfgBits[`CS_TRACE_MON]))
                monitorMode <= 1'b1;
            else if (resumeCmd)
                monitorMode <= 1'b0;
            emuSpecialSpace  <= monitorMode && cfgBits[`CS_MAP];
            sramCacheDisable <= monitorMode && cfgBits[`CS_MAP];

            emuTypeOut <= (monitorMode && cfgBits[`CS_MAP]) ? `TT_EMULATOR : `TT_NORMAL;

            serialExecution   <= cfgBits[`CS_SERIAL_EXEC];
            serialExtraCycles <= cfgBits[`CS_SERIAL_EXEC] ? `SERIAL_EXTRA_CYC : 3'h0;

            singleStepHalt <= cfgBits[`CS_SINGLE_STEP] && stepArmed && instrSample;

            irqAccept <= irqRequest && !(cfgBits[`CS_SINGLE_STEP] && cfgBits[`CS_IGNORE_IRQ]);

            ownershipEmit <= cfgBits[`CS_OWN_TRACE] && (userEntry || spaceIdLoad || syncPcCmd);

            operandCaptureSel <= cfgBits[12:11];
            branchTargetCount <= cfgBits[9:8];
        end
    end

endmodule // debug_config_attr_match
`default_nettype wire

// ### test/debug_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module debug_host_model (
    input  wire logic linkOn,
    output var  logic traceClockIn,
    output var  logic externalBreakIn
);
    // Link clock at 64 ns, free of the core clock phase, and still outside frames.
    initial begin
        traceClockIn = 1'b0;
        externalBreakIn = 1'b1;
        #3;
        forever begin
            #32;
            traceClockIn = linkOn ? ~traceClockIn : 1'b0;
        end
    end
    task automatic breakEdge();
        externalBreakIn = 1'b0;
        #200;
        externalBreakIn = 1'b1;
    endtask
endmodule // debug_host_model
`default_nettype wire

// ### test/debug_cfg_properties.sv
`timescale 1ns/1ps
`default_nettype none
module debug_cfg_properties #(
    parameter [3:0] REVISION = 4'h3
) (
    input wire logic        clk, rst_b, portWrite, portRead, cpuWrite, memCmd, memCmdRead,
    input wire logic        coreHalted, readValid, debugModeOut, debugIrq, traceClockOut,
    input wire logic        emuSpecialSpace, serialExecution,
    input wire logic [4:0]  regSel,
    input wire logic [31:0] writeData, readData,
    input wire logic [7:0]  memAttr,
    input wire logic [1:0]  memCmdSize, emuTypeOut, operandCaptureSel, branchTargetCount
);
    logic [31:0] cfg;
    // Shadow of the configuration word; processor writes cannot touch the block bit.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg <= 32'h0000_0000;
        end else if (portWrite && regSel == 5'h00) begin
            cfg <= writeData;
        end else if (cpuWrite && regSel == 5'h00 && !cfg[16]) begin
            cfg <= {writeData[31:17], cfg[16], writeData[15:0]};
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    dbg_out_a: assert property (
        debugModeOut == $past(cfg[1] | (coreHalted & ~cfg[0]))) else $error("debug out wrong");
    read_answer_a: assert property (
        portRead && regSel == 5'h00 |=> readValid && readData[23:20] == REVISION)
        else $error("read answer wrong");
    read_cause_a: assert property (
        readValid |-> $past(portRead)) else $error("read without port request");
    mem_cmd_a: assert property (
        memCmd |=> memAttr[7:5] == $past({memCmdRead, memCmdSize}))
        else $error("memory attribute not loaded");
    cfg_fields_a: assert property (
        operandCaptureSel == $past(cfg[12:11]) && branchTargetCount == $past(cfg[9:8]))
        else $error("trace field outputs wrong");
    serial_mode_a: assert property (
        serialExecution == $past(cfg[6])) else $error("serial mode output wrong");
    trace_quiet_a: assert property (
        cfg[17] && $past(cfg[17], 3) |-> !traceClockOut) else $error("trace clock not quiet");
    irq_pulse_a: assert property (
        debugIrq |-> cfg[18] ##1 !debugIrq) else $error("debug interrupt wrong");
    map_space_a: assert property (
        emuSpecialSpace |-> emuTypeOut == 2'h2) else $error("special space type wrong");
    cover property (readValid);
    cover property (debugIrq);
    cover property (memCmd);
endmodule // debug_cfg_properties
bind debug_config_attr_match debug_cfg_properties #(.REVISION(REVISION)) i_props (.*);
`default_nettype wire

// ### test/debug_config_and_attr_match_tb_top.sv
`include "debug_cfg_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module debug_config_and_attr_match_tb_top;
    localparam logic [3:0] REV = 4'hA; // Arbitrary revision value.
    logic        clk, rst_b, portWrite, portRead, cpuWrite, coreHalted, traceIdle, linkOn;
    logic        memCmdRead, busValid, busRead, readValid, debugModeOut, debugIrq;
    logic        traceClockOut, attrMatch0, attrMatch1, monitorMode, emuSpecialSpace;
    logic        sramCacheDisable, serialExecution, singleStepHalt, irqAccept, ownershipEmit;
    logic [4:0]  regSel;
    logic [31:0] writeData, readData, rd, w;
    logic [1:0]  memCmdSize, busSize, busType, emuTypeOut, operandCaptureSel, branchTargetCount;
    logic [2:0]  busModifier, serialExtraCycles;
    logic [7:0]  currentSpaceId, traceNibbleIn, busSpaceId, traceNibbleBus, memAttr;
    logic [13:0] evt;
    wire         externalBreakIn, traceClockIn, syncPcCmd, spaceIdLoad, userEntry, irqRequest;
    wire         traceException, level2Hit, resumeCmd, level1Hit, catastrophicHalt;
    wire         enterDebugTrigger, enterDebugHalt, enterDebugBreak, memCmd, instrSample;
    int          n_fail = 0, cmp_count = 0, rises = 0, irqs = 0;
    // Attribute trigger table: match word, and {trigger enable, modifier, space id, expected}.
    logic [31:0] aTab [7] = '{32'h0000_00D5, 32'h0000_00D5, 32'h0000_07D5, 32'h0142_00D5,
                              32'h0142_00D5, 32'h0042_00D5, 32'h0000_00D5};
    logic [12:0] bTab [7] = '{13'h1A01, 13'h1800, 13'h1801, 13'h1A85, 13'h1A86, 13'h1A87,
                              13'h0A00};
    // One-cycle event pulses from a single vector.
    assign {syncPcCmd, spaceIdLoad, userEntry, irqRequest, traceException, level2Hit,
            resumeCmd, level1Hit, catastrophicHalt, enterDebugTrigger, enterDebugHalt,
            enterDebugBreak, memCmd, instrSample} = evt;
    debug_config_attr_match #(.REVISION(REV)) i_dut (.*);
    debug_host_model i_host (.*);
    // Core clock and event counters.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge traceClockOut) rises++;
    always @(posedge clk) if (debugIrq === 1'b1) irqs++;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Register write from the debug port or from the processor.
    task automatic wr(input logic cpu, input logic [4:0] sel, input logic [31:0] d);
        @(posedge clk);
        {portWrite, cpuWrite, regSel, writeData} <= {!cpu, cpu, sel, d};
        @(posedge clk);
        {portWrite, cpuWrite} <= 2'b00;
    endtask
    task automatic rdp(output logic [31:0] d);
        @(posedge clk);
        regSel   <= `REG_CONFIG_STATUS;
        portRead <= 1'b1;
        @(posedge clk);
        portRead <= 1'b0;
        #1;
        for (int i = 0; i < 4 && readValid !== 1'b1; i++) @(posedge clk) #1;
        check("readValid", readValid, 1'b1);
        d = readData;
    endtask
    task automatic pulse(input logic [13:0] v);
        @(posedge clk);
        evt <= v;
        @(posedge clk);
        evt <= 14'h0000;
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Watchdog against a hang.
    initial begin
        #300000;
        n_fail++;
        end_of_test();
    end
    // Main sequence.
    initial begin
        {portWrite, portRead, cpuWrite, coreHalted, traceIdle, linkOn, memCmdRead} = '0;
        {busValid, busRead, memCmdSize, busSize, busType, busModifier, regSel} = '0;
        {writeData, currentSpaceId, traceNibbleIn, busSpaceId, evt} = '0;
        rst_b = 1'b0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        tick(1);
        check("memAttr reset", memAttr, `MEM_ATTR_RESET);
        rdp(rd);
        check("revision", rd[23:20], REV);
        check("status reset", rd[31:24], 8'h00);
        for (int i = 0; i < 8; i++) begin
            wr(0, `REG_CONFIG_STATUS, i & 3);
            @(posedge clk) coreHalted <= i[2];
            tick(3);
            check("debugModeOut", debugModeOut, i[1] | (i[2] & ~i[0]));
        end
        for (int i = 0; i < 4; i++) begin
            w = {16'h0, i[1], 1'b0, i[1], i[1:0], 1'b0, i[1:0], 1'b0, i[0], 6'h00};
            wr(0, `REG_CONFIG_STATUS, w);
            tick(3);
            check("operandCaptureSel", operandCaptureSel, i);
            check("branchTargetCount", branchTargetCount, i);
            check("serialExecution", serialExecution, i[0]);
            check("sramCacheDisable", sramCacheDisable, i[1]);
            check("serialExtraCycles", serialExtraCycles, i[0] ? `SERIAL_EXTRA_CYC : 3'h0);
            check("monitorMode", monitorMode, i[1]);
            check("emuTypeOut", emuTypeOut, i[1] ? `TT_EMULATOR : `TT_NORMAL);
            rdp(rd);
            check("config readback", rd[15:0], w[15:0]);
        end
        wr(0, `REG_CONFIG_STATUS, 32'h0001_0000);
        wr(1, `REG_CONFIG_STATUS, 32'h0000_0000);
        wr(1, `REG_CONFIG_STATUS, 32'h0000_1800);
        tick(3);
        check("blocked write", operandCaptureSel, 2'h0);
        rdp(rd);
        check("block bit", rd[16], 1'b1);
        wr(0, `REG_CONFIG_STATUS, 32'h0000_0000);
        wr(1, `REG_CONFIG_STATUS, 32'h0000_1800);
        tick(3);
        check("processor write", operandCaptureSel, 2'h3);
        for (int i = 2; i < 6; i++) begin
            pulse(1 << i);
            tick(2);
            rdp(rd);
            check("halt cause", rd[27:24], 1 << (i - 2));
            pulse(14'h0080);
            tick(2);
            rdp(rd);
            check("cause cleared", rd[27:24], 4'h0);
        end
        wr(0, `REG_TRIG_DEF, 32'h0000_2000);
        tick(3);
        rdp(rd);
        check("state waiting", rd[31:28], `TSTATE_WAIT_L1);
        pulse(14'h0040);
        tick(2);
        rdp(rd);
        check("state hit", rd[31:28], `TSTATE_HIT_L1);
        wr(0, `REG_TRIG_DEF, 32'h0000_0000);
        tick(3);
        rdp(rd);
        check("state cleared", rd[31:28], `TSTATE_NONE);
        @(posedge clk) {memCmdRead, memCmdSize} <= 3'b110;
        pulse(14'h0002);
        tick(2);
        check("memAttr command", memAttr[7:5], 3'b110);
        wr(0, `REG_MEM_ATTR, 32'h0000_000D);
        tick(3);
        check("memAttr write", memAttr, 8'hCD);
        @(posedge clk) {busValid, busRead, busSize, busType} <= {2'b11, 2'h2, `TT_EMULATOR};
        for (int i = 0; i < 7; i++) begin
            wr(0, `REG_TRIG_DEF, {18'h0, bTab[i][12], 13'h0});
            wr(0, `REG_ATTR_MATCH_0, aTab[i]);
            @(posedge clk) {busModifier, busSpaceId} <= bTab[i][11:1];
            tick(3);
            check("attrMatch0", attrMatch0, bTab[i][0]);
        end
        check("memAttr from match", memAttr, 8'hD5);
        wr(0, `REG_CONFIG_STATUS, 32'h0002_0000);
        @(posedge clk) linkOn <= 1'b1;
        rises = 0;
        tick(100);
        check("trace clock held", rises, 0);
        wr(0, `REG_CONFIG_STATUS, 32'h0000_0000);
        tick(3);
        rises = 0;
        tick(100);
        check("trace clock runs", rises != 0, 1);
        @(posedge clk) {linkOn, traceIdle, currentSpaceId} <= {2'b01, 8'h3C};
        i_host.breakEdge();
        tick(4);
        check("break ignored", irqs, 0);
        wr(0, `REG_CONFIG_STATUS, 32'h0004_0008);
        tick(3);
        fork
            i_host.breakEdge();
        join_none
        repeat (30) pulse(14'h0001);
        check("debug interrupt", irqs, 1);
        for (int i = 8; i < 14; i++) begin
            pulse(1 << i);
            #1;
            check("ownershipEmit", ownershipEmit, i > 10);
            check("trace id or idle", traceNibbleBus, (i > 10) ? 8'h3C : 8'h00);
            check("irqAccept", irqAccept, i == 10);
        end
        wr(0, `REG_EXT_TRIG_DEF, 32'h0000_2000);
        wr(0, `REG_ATTR_MATCH_1, aTab[0]);
        tick(3);
        check("attrMatch1", attrMatch1, 1'b1);
        check("attrMatch0 off", attrMatch0, 1'b0);
        wr(0, `REG_CONFIG_STATUS, 32'h0000_0030);
        pulse(14'h0080);
        pulse(14'h0001);
        #1;
        check("step halt", singleStepHalt, 1'b1);
        pulse(14'h0001);
        #1;
        check("second step", singleStepHalt, 1'b0);
        pulse(14'h0400);
        #1;
        check("irq ignored in step", irqAccept, 1'b0);
        end_of_test();
    end
endmodule // debug_config_and_attr_match_tb_top
`default_nettype wire
